//--- core/crf_map.vh
// Constants shared by the CPU register file and flag logic
`ifndef CRF_MAP_VH
`define CRF_MAP_VH

// ----------------------------------------
// Condition register bit positions
// ----------------------------------------
`define CRF_FLAG_I 7
`define CRF_FLAG_U6 6
`define CRF_FLAG_H 5
`define CRF_FLAG_U4 4
`define CRF_FLAG_N 3
`define CRF_FLAG_Z 2
`define CRF_FLAG_V 1
`define CRF_FLAG_C 0
`define CRF_FLAGS_RESET 8'h80

// ----------------------------------------
// Program counter, vector and stack
// ----------------------------------------
`define CRF_RESET_VECTOR 16'h0000
`define CRF_PC_STEP 16'h0002
`define CRF_SP_STEP 16'h0002
`define CRF_SP_INDEX 3'h7
`define CRF_WORD_MASK 16'hFFFF
`define CRF_BYTE_MASK 16'h00FF

// ----------------------------------------
// Arithmetic and logic operations
// ----------------------------------------
`define CRF_OP_ADD 4'h0
`define CRF_OP_ADDX 4'h1
`define CRF_OP_SUB 4'h2
`define CRF_OP_SUBX 4'h3
`define CRF_OP_CMP 4'h4
`define CRF_OP_NEG 4'h5
`define CRF_OP_SHL 4'h6
`define CRF_OP_SHR 4'h7
`define CRF_OP_ROTL 4'h8
`define CRF_OP_ROTR 4'h9
`define CRF_OP_DAA 4'hA
`define CRF_OP_DAS 4'hB
`define CRF_OP_AND 4'hC
`define CRF_OP_OR 4'hD
`define CRF_OP_XOR 4'hE
`define CRF_OP_MOV 4'hF

// ----------------------------------------
// Bit operations on the carry accumulator
// ----------------------------------------
`define CRF_BIT_LOAD 3'h0
`define CRF_BIT_ILOAD 3'h1
`define CRF_BIT_STORE 3'h2
`define CRF_BIT_ISTORE 3'h3
`define CRF_BIT_AND 3'h4
`define CRF_BIT_OR 3'h5
`define CRF_BIT_XOR 3'h6
`define CRF_BIT_TEST 3'h7

// ----------------------------------------
// Condition register instructions
// ----------------------------------------
`define CRF_FLG_LOAD 2'h0
`define CRF_FLG_AND 2'h1
`define CRF_FLG_OR 2'h2
`define CRF_FLG_XOR 2'h3

`endif

//--- core/crf_gpr.v
// General register storage: sixteen bytes seen as eight words
`include "crf_map.vh"

module crf_gpr (
	clk,
	ce,
	we,
	wsel,
	wword,
	wdata,
	ra_sel,
	ra_word,
	ra_data,
	rb_sel,
	rb_word,
	rb_data,
	raddr_sel,
	raddr_data,
	sp_data
);
	input wire clk;
	input wire ce;
	input wire we;
	input wire [3:0] wsel;
	input wire wword;
	input wire [15:0] wdata;
	input wire [3:0] ra_sel;
	input wire ra_word;
	output wire [15:0] ra_data;
	input wire [3:0] rb_sel;
	input wire rb_word;
	output wire [15:0] rb_data;
	input wire [2:0] raddr_sel;
	output wire [15:0] raddr_data;
	output wire [15:0] sp_data;

	// Entries 0..7 hold upper bytes, 8..15 the lower bytes of the same words
	reg [7:0] mem [0:15];

	// Bytes are passed in so that a write to the array re-evaluates every read port
	function [15:0] crf_read;
		input word;
		input [7:0] hi;
		input [7:0] lo;
		input [7:0] one;
		begin
			if (word) begin
				crf_read = {hi, lo};
			end else begin
				crf_read = {8'h00, one};
			end
		end
	endfunction

	assign ra_data = crf_read(ra_word, mem[{1'b0, ra_sel[2:0]}], mem[{1'b1, ra_sel[2:0]}],
		mem[ra_sel]);
	assign rb_data = crf_read(rb_word, mem[{1'b0, rb_sel[2:0]}], mem[{1'b1, rb_sel[2:0]}],
		mem[rb_sel]);
	assign raddr_data = crf_read(1'b1, mem[{1'b0, raddr_sel}], mem[{1'b1, raddr_sel}],
		8'h00);
	assign sp_data = crf_read(1'b1, mem[{1'b0, `CRF_SP_INDEX}], mem[{1'b1, `CRF_SP_INDEX}],
		8'h00);

	// No reset: contents stay undefined until software writes them
	always @(posedge clk) begin
		if (ce && we) begin
			if (wword) begin
				mem[{1'b0, wsel[2:0]}] <= wdata[15:8];
				mem[{1'b1, wsel[2:0]}] <= wdata[7:0];
			end else begin
				mem[wsel] <= wdata[7:0];
			end
		end
	end
endmodule

//--- core/crf_alu.v
// Result and condition flag computation for one operation
`include "crf_map.vh"

module crf_alu (
	op,
	word,
	a,
	b,
	c_in,
	h_in,
	result,
	n_out,
	z_out,
	v_out,
	c_out,
	h_out,
	c_upd,
	h_upd
);
	input wire [3:0] op;
	input wire word;
	input wire [15:0] a;
	input wire [15:0] b;
	input wire c_in;
	input wire h_in;
	output reg [15:0] result;
	output reg n_out;
	output reg z_out;
	output reg v_out;
	output reg c_out;
	output reg h_out;
	output reg c_upd;
	output reg h_upd;

	reg [15:0] msk;
	reg [15:0] x;
	reg [15:0] y;
	reg [16:0] full;
	reg [12:0] part;
	reg [4:0] nib;
	reg [7:0] adj;
	reg ci;
	reg sub;

	function crf_msb;
		input [15:0] val;
		input wd;
		begin
			crf_msb = wd ? val[15] : val[7];
		end
	endfunction

	always @* begin
		msk = word ? `CRF_WORD_MASK : `CRF_BYTE_MASK;
		x = a & msk;
		y = b & msk;
		ci = 1'b0;
		sub = 1'b0;
		full = 17'h00000;
		part = 13'h0000;
		nib = 5'h00;
		adj = 8'h00;
		result = 16'h0000;
		v_out = 1'b0;
		c_out = c_in;
		h_out = h_in;
		c_upd = 1'b0;
		h_upd = 1'b0;
		case (op)
			`CRF_OP_ADD, `CRF_OP_ADDX, `CRF_OP_SUB, `CRF_OP_SUBX, `CRF_OP_CMP, `CRF_OP_NEG: begin
				ci = (op == `CRF_OP_ADDX || op == `CRF_OP_SUBX) ? c_in : 1'b0;
				sub = !(op == `CRF_OP_ADD || op == `CRF_OP_ADDX);
				if (op == `CRF_OP_NEG) begin
					y = x;
					x = 16'h0000;
				end
				if (sub) begin
					full = {1'b0, x} - {1'b0, y} - {16'h0000, ci};
					part = {1'b0, x[11:0]} - {1'b0, y[11:0]} - {12'h000, ci};
					nib = {1'b0, x[3:0]} - {1'b0, y[3:0]} - {4'h0, ci};
				end else begin
					full = {1'b0, x} + {1'b0, y} + {16'h0000, ci};
					part = {1'b0, x[11:0]} + {1'b0, y[11:0]} + {12'h000, ci};
					nib = {1'b0, x[3:0]} + {1'b0, y[3:0]} + {4'h0, ci};
				end
				result = full[15:0] & msk;
				h_out = word ? part[12] : nib[4];
				h_upd = 1'b1;
				c_out = word ? full[16] : full[8];
				c_upd = 1'b1;
				if (sub) begin
					v_out = (crf_msb(x, word) != crf_msb(y, word)) &&
						(crf_msb(result, word) != crf_msb(x, word));
				end else begin
					v_out = (crf_msb(x, word) == crf_msb(y, word)) &&
						(crf_msb(result, word) != crf_msb(x, word));
				end
			end
			`CRF_OP_SHL: begin
				result = (x << 1) & msk;
				c_out = crf_msb(x, word);
				c_upd = 1'b1;
			end
			`CRF_OP_SHR: begin
				result = x >> 1;
				c_out = x[0];
				c_upd = 1'b1;
			end
			`CRF_OP_ROTL: begin
				result = ((x << 1) | {15'h0000, crf_msb(x, word)}) & msk;
				c_out = crf_msb(x, word);
				c_upd = 1'b1;
			end
			`CRF_OP_ROTR: begin
				result = (x >> 1) | (word ? {x[0], 15'h0000} : {8'h00, x[0], 7'h00});
				c_out = x[0];
				c_upd = 1'b1;
			end
			`CRF_OP_DAA: begin
				adj[3:0] = (h_in || x[3:0] > 4'h9) ? 4'h6 : 4'h0;
				adj[7:4] = (c_in || x[7:0] > 8'h99) ? 4'h6 : 4'h0;
				result = {8'h00, x[7:0] + adj};
				c_out = c_in || (x[7:0] > 8'h99);
				c_upd = 1'b1;
			end
			`CRF_OP_DAS: begin
				adj[3:0] = h_in ? 4'h6 : 4'h0;
				adj[7:4] = c_in ? 4'h6 : 4'h0;
				result = {8'h00, x[7:0] - adj};
			end
			`CRF_OP_AND: result = x & y;
			`CRF_OP_OR: result = x | y;
			`CRF_OP_XOR: result = x ^ y;
			default: result = y;
		endcase
		n_out = crf_msb(result, word);
		z_out = (result == 16'h0000);
	end
endmodule

//--- core/crf_core.v
// CPU general registers, program counter and condition register
`include "crf_map.vh"

// Function
// - Sixteen byte registers pair into eight word registers on shared storage.
// - Data operands read or write a full word, upper byte or lower byte.
// - Address operands are always read as full word registers.
// - Register seven serves as stack pointer for exceptions and calls.
// - Word program counter; fetch by word, lowest bit forced to zero.
// - Condition bit 7 set masks interrupts; software reads and writes it.
// - Every exception start sets the interrupt mask bit.
// - Condition bits 6 and 4 are plain user storage.
// - Byte arithmetic sets half-carry from carry or borrow at bit 3.
// - Word add, subtract, compare set half-carry from bit 11.
// - Negative flag takes the result sign bit.
// - Zero flag set for zero result, cleared otherwise.
// - Overflow flag set on arithmetic overflow, cleared otherwise.
// - Carry flag: add carry, subtract borrow, shifted-out bit.
// - Bit operations use the carry flag as single-bit accumulator.
// - Branch conditions come from negative, zero, overflow and carry flags.
// - Software loads, stores, ANDs, ORs and XORs the whole condition register.
// - Reset loads program counter from vector at 0000 and sets mask.
// - Reset clears other condition bits; general registers stay uninitialised.
// - Single bits are numbered zero to seven within a byte operand.
// - Decimal adjust treats a byte as two BCD digits using half-carry.
module crf_core (
	clk,
	resetn,
	ce,
	opa_sel,
	opa_word,
	opa_data,
	opb_sel,
	opb_word,
	opb_data,
	addr_sel,
	addr_data,
	wr_en,
	wr_sel,
	wr_word,
	wr_data,
	alu_go,
	alu_op,
	alu_word,
	alu_a,
	alu_b,
	alu_wb,
	alu_dst,
	alu_result,
	alu_done,
	bit_go,
	bit_op,
	bit_num,
	bit_byte,
	bit_result,
	bit_done,
	flg_go,
	flg_op,
	flg_imm,
	condition_flags,
	irq_masked,
	br_cond,
	br_taken,
	pc_step,
	pc_load,
	pc_target,
	program_counter,
	fetch_addr,
	vec_req,
	vec_addr,
	vec_valid,
	vec_data,
	cpu_ready,
	sp_push,
	sp_pop,
	stack_pointer,
	exc_start
);
	input wire clk;
	input wire resetn;
	input wire ce;
	input wire [3:0] opa_sel;
	input wire opa_word;
	output reg [15:0] opa_data;
	input wire [3:0] opb_sel;
	input wire opb_word;
	output reg [15:0] opb_data;
	input wire [2:0] addr_sel;
	output reg [15:0] addr_data;
	input wire wr_en;
	input wire [3:0] wr_sel;
	input wire wr_word;
	input wire [15:0] wr_data;
	input wire alu_go;
	input wire [3:0] alu_op;
	input wire alu_word;
	input wire [15:0] alu_a;
	input wire [15:0] alu_b;
	input wire alu_wb;
	input wire [3:0] alu_dst;
	output reg [15:0] alu_result;
	output reg alu_done;
	input wire bit_go;
	input wire [2:0] bit_op;
	input wire [2:0] bit_num;
	input wire [7:0] bit_byte;
	output reg [7:0] bit_result;
	output reg bit_done;
	input wire flg_go;
	input wire [1:0] flg_op;
	input wire [7:0] flg_imm;
	output wire [7:0] condition_flags;
	output wire irq_masked;
	input wire [3:0] br_cond;
	output wire br_taken;
	input wire pc_step;
	input wire pc_load;
	input wire [15:0] pc_target;
	output wire [15:0] program_counter;
	output wire [15:0] fetch_addr;
	output wire vec_req;
	output wire [15:0] vec_addr;
	input wire vec_valid;
	input wire [15:0] vec_data;
	output wire cpu_ready;
	input wire sp_push;
	input wire sp_pop;
	output wire [15:0] stack_pointer;
	input wire exc_start;

	// ----------------------------------------
	// States and storage
	// ----------------------------------------
	localparam ST_VECTOR = 1'b0;
	localparam ST_RUN = 1'b1;

	reg state_reg;
	reg state_next;
	reg [15:0] pc_reg;
	reg [15:0] pc_next;
	reg [7:0] flags_reg;
	reg [7:0] flags_next;
	reg gpr_we;
	reg [3:0] gpr_wsel;
	reg gpr_wword;
	reg [15:0] gpr_wdata;
	reg bit_val;
	reg bit_acc;
	reg [7:0] bit_byte_next;

	wire [15:0] gpr_a;
	wire [15:0] gpr_b;
	wire [15:0] gpr_addr;
	wire [15:0] sp_data;
	wire [15:0] alu_res;
	wire alu_n;
	wire alu_z;
	wire alu_v;
	wire alu_c;
	wire alu_h;
	wire alu_c_upd;
	wire alu_h_upd;
	wire running;

	assign running = (state_reg == ST_RUN);

	// ----------------------------------------
	// Helper functions
	// ----------------------------------------
	function crf_cond;
		input [3:0] cond;
		input [7:0] f;
		reg n;
		reg z;
		reg v;
		reg c;
		begin
			n = f[`CRF_FLAG_N];
			z = f[`CRF_FLAG_Z];
			v = f[`CRF_FLAG_V];
			c = f[`CRF_FLAG_C];
			case (cond)
				4'h0: crf_cond = 1'b1;
				4'h1: crf_cond = 1'b0;
				4'h2: crf_cond = !(c || z);
				4'h3: crf_cond = c || z;
				4'h4: crf_cond = !c;
				4'h5: crf_cond = c;
				4'h6: crf_cond = !z;
				4'h7: crf_cond = z;
				4'h8: crf_cond = !v;
				4'h9: crf_cond = v;
				4'hA: crf_cond = !n;
				4'hB: crf_cond = n;
				4'hC: crf_cond = !(n ^ v);
				4'hD: crf_cond = n ^ v;
				4'hE: crf_cond = !(z || (n ^ v));
				default: crf_cond = z || (n ^ v);
			endcase
		end
	endfunction

	function [15:0] crf_even;
		input [15:0] addr;
		begin
			crf_even = {addr[15:1], 1'b0};
		end
	endfunction

	// ----------------------------------------
	// Submodules
	// ----------------------------------------
	crf_gpr u_gpr (
		.clk(clk),
		.ce(ce),
		.we(gpr_we),
		.wsel(gpr_wsel),
		.wword(gpr_wword),
		.wdata(gpr_wdata),
		.ra_sel(opa_sel),
		.ra_word(opa_word),
		.ra_data(gpr_a),
		.rb_sel(opb_sel),
		.rb_word(opb_word),
		.rb_data(gpr_b),
		.raddr_sel(addr_sel),
		.raddr_data(gpr_addr),
		.sp_data(sp_data)
	);

	crf_alu u_alu (
		.op(alu_op),
		.word(alu_word),
		.a(alu_a),
		.b(alu_b),
		.c_in(flags_reg[`CRF_FLAG_C]),
		.h_in(flags_reg[`CRF_FLAG_H]),
		.result(alu_res),
		.n_out(alu_n),
		.z_out(alu_z),
		.v_out(alu_v),
		.c_out(alu_c),
		.h_out(alu_h),
		.c_upd(alu_c_upd),
		.h_upd(alu_h_upd)
	);

	// ----------------------------------------
	// Register write arbitration
	// ----------------------------------------
	// Stack adjust wins over write-back, which wins over a plain write
	always @* begin
		gpr_we = 1'b0;
		gpr_wsel = wr_sel;
		gpr_wword = wr_word;
		gpr_wdata = wr_data;
		if (running && sp_push) begin
			gpr_we = 1'b1;
			gpr_wsel = {1'b0, `CRF_SP_INDEX};
			gpr_wword = 1'b1;
			gpr_wdata = sp_data - `CRF_SP_STEP;
		end else if (running && sp_pop) begin
			gpr_we = 1'b1;
			gpr_wsel = {1'b0, `CRF_SP_INDEX};
			gpr_wword = 1'b1;
			gpr_wdata = sp_data + `CRF_SP_STEP;
		end else if (alu_go && alu_wb && alu_op != `CRF_OP_CMP) begin
			gpr_we = 1'b1;
			gpr_wsel = alu_dst;
			gpr_wword = alu_word;
			gpr_wdata = alu_res;
		end else if (wr_en) begin
			gpr_we = 1'b1;
		end
	end

	// ----------------------------------------
	// Bit accumulator
	// ----------------------------------------
	always @* begin
		bit_val = bit_byte[bit_num];
		bit_acc = flags_reg[`CRF_FLAG_C];
		bit_byte_next = bit_byte;
		case (bit_op)
			`CRF_BIT_LOAD: bit_acc = bit_val;
			`CRF_BIT_ILOAD: bit_acc = !bit_val;
			`CRF_BIT_STORE: bit_byte_next[bit_num] = flags_reg[`CRF_FLAG_C];
			`CRF_BIT_ISTORE: bit_byte_next[bit_num] = !flags_reg[`CRF_FLAG_C];
			`CRF_BIT_AND: bit_acc = bit_acc & bit_val;
			`CRF_BIT_OR: bit_acc = bit_acc | bit_val;
			`CRF_BIT_XOR: bit_acc = bit_acc ^ bit_val;
			default: bit_acc = flags_reg[`CRF_FLAG_C];
		endcase
	end

	// ----------------------------------------
	// Condition register next value
	// ----------------------------------------
	always @* begin
		flags_next = flags_reg;
		if (flg_go) begin
			case (flg_op)
				`CRF_FLG_LOAD: flags_next = flg_imm;
				`CRF_FLG_AND: flags_next = flags_reg & flg_imm;
				`CRF_FLG_OR: flags_next = flags_reg | flg_imm;
				default: flags_next = flags_reg ^ flg_imm;
			endcase
		end else if (alu_go) begin
			flags_next[`CRF_FLAG_N] = alu_n;
			flags_next[`CRF_FLAG_Z] = alu_z;
			flags_next[`CRF_FLAG_V] = alu_v;
			if (alu_c_upd) begin
				flags_next[`CRF_FLAG_C] = alu_c;
			end
			if (alu_h_upd) begin
				flags_next[`CRF_FLAG_H] = alu_h;
			end
		end else if (bit_go) begin
			if (bit_op == `CRF_BIT_TEST) begin
				flags_next[`CRF_FLAG_Z] = !bit_val;
			end else begin
				flags_next[`CRF_FLAG_C] = bit_acc;
			end
		end
		if (exc_start) begin
			flags_next[`CRF_FLAG_I] = 1'b1;
		end
	end

	// ----------------------------------------
	// Program counter and reset sequence
	// ----------------------------------------
	always @* begin
		state_next = state_reg;
		pc_next = pc_reg;
		case (state_reg)
			ST_VECTOR: begin
				if (vec_valid) begin
					pc_next = crf_even(vec_data);
					state_next = ST_RUN;
				end
			end
			default: begin
				if (pc_load) begin
					pc_next = crf_even(pc_target);
				end else if (pc_step) begin
					pc_next = pc_reg + `CRF_PC_STEP;
				end
			end
		endcase
	end

	// ----------------------------------------
	// Clocked state
	// ----------------------------------------
	// Only the mask bit has a documented reset value; the rest reset to zero
	always @(posedge clk) begin
		if (!resetn) begin
			state_reg <= ST_VECTOR;
			pc_reg <= `CRF_RESET_VECTOR;
			flags_reg <= `CRF_FLAGS_RESET;
			opa_data <= 16'h0000;
			opb_data <= 16'h0000;
			addr_data <= 16'h0000;
			alu_result <= 16'h0000;
			alu_done <= 1'b0;
			bit_result <= 8'h00;
			bit_done <= 1'b0;
		end else if (ce) begin
			state_reg <= state_next;
			pc_reg <= pc_next;
			flags_reg <= flags_next;
			opa_data <= gpr_a;
			opb_data <= gpr_b;
			addr_data <= gpr_addr;
			alu_done <= alu_go;
			bit_done <= bit_go;
			if (alu_go) begin
				alu_result <= alu_res;
			end
			if (bit_go) begin
				bit_result <= bit_byte_next;
			end
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign condition_flags = flags_reg;
	assign irq_masked = flags_reg[`CRF_FLAG_I];
	assign br_taken = crf_cond(br_cond, flags_reg);
	assign program_counter = pc_reg;
	assign fetch_addr = crf_even(pc_reg);
	assign vec_req = !running;
	assign vec_addr = `CRF_RESET_VECTOR;
	assign cpu_ready = running;
	assign stack_pointer = sp_data;
endmodule

//--- verif/crf_core_assertions.sv
// Concurrent checks on the register file and flag ports
`include "crf_map.vh"
module crf_core_assertions (
	input wire clk,
	input wire resetn,
	input wire ce,
	input wire opa_word,
	input wire [15:0] opa_data,
	input wire alu_go,
	input wire [3:0] alu_op,
	input wire alu_word,
	input wire [15:0] alu_a,
	input wire [15:0] alu_b,
	input wire [15:0] alu_result,
	input wire flg_go,
	input wire [1:0] flg_op,
	input wire [7:0] flg_imm,
	input wire [7:0] condition_flags,
	input wire irq_masked,
	input wire [3:0] br_cond,
	input wire br_taken,
	input wire [15:0] program_counter,
	input wire [15:0] fetch_addr,
	input wire vec_req,
	input wire vec_valid,
	input wire [15:0] vec_data,
	input wire cpu_ready,
	input wire exc_start
);
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	wire [4:0] h_lo = {1'b0, alu_a[3:0]} + {1'b0, alu_b[3:0]};
	wire [12:0] h_hi = {1'b0, alu_a[11:0]} + {1'b0, alu_b[11:0]};
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	sequence s_vec_take;
		ce && vec_req && vec_valid;
	endsequence
	// Flag ops override ALU flags and exceptions set the mask bit, so both are excluded
	sequence s_alu_take;
		ce && alu_go && !flg_go && !exc_start;
	endsequence
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	property p_pc_even;
		fetch_addr == {program_counter[15:1], 1'b0};
	endproperty
	a_pc_even: assert property (p_pc_even) else $error("fetch address not even");
	property p_irq;
		ce && flg_go && flg_op == `CRF_FLG_LOAD && !exc_start |=>
			irq_masked == ($past(flg_imm) >= 8'h80);
	endproperty
	a_irq: assert property (p_irq) else $error("mask output differs from flag");
	property p_exc;
		ce && exc_start |=> condition_flags[7];
	endproperty
	a_exc: assert property (p_exc) else $error("exception did not set mask");
	property p_reset;
		disable iff (1'b0) ce && !resetn |=> condition_flags == 8'h80 && !cpu_ready && vec_req;
	endproperty
	a_reset: assert property (p_reset) else $error("bad state after reset");
	property p_vec;
		s_vec_take |=> cpu_ready && program_counter == ($past(vec_data) & 16'hFFFE);
	endproperty
	a_vec: assert property (p_vec) else $error("vector not loaded");
	property p_h_byte;
		s_alu_take ##0 (alu_op == `CRF_OP_ADD && !alu_word) |=>
			condition_flags[5] == ($past(h_lo) >= 5'h10);
	endproperty
	a_h_byte: assert property (p_h_byte) else $error("byte half-carry wrong");
	property p_h_word;
		s_alu_take ##0 (alu_op == `CRF_OP_ADD && alu_word) |=>
			condition_flags[5] == ($past(h_hi) >= 13'h1000);
	endproperty
	a_h_word: assert property (p_h_word) else $error("word half-carry wrong");
	property p_zero;
		s_alu_take ##0 (alu_op != `CRF_OP_CMP) |=>
			condition_flags[2] == ($past(alu_word) ? alu_result == 16'h0000 : alu_result[7:0] == 8'h00);
	endproperty
	a_zero: assert property (p_zero) else $error("zero flag wrong");
	property p_neg;
		s_alu_take ##0 (alu_op != `CRF_OP_CMP) |=>
			condition_flags[3] == ($past(alu_word) ? alu_result[15] : alu_result[7]);
	endproperty
	a_neg: assert property (p_neg) else $error("negative flag wrong");
	property p_branch;
		br_cond == 4'h7 |-> br_taken == condition_flags[2];
	endproperty
	a_branch: assert property (p_branch) else $error("equal branch wrong");
	property p_flg_load;
		ce && flg_go && flg_op == `CRF_FLG_LOAD && !exc_start |=> condition_flags == $past(flg_imm);
	endproperty
	a_flg_load: assert property (p_flg_load) else $error("flag load wrong");
	property p_byte_read;
		ce && !opa_word |=> opa_data[15:8] == 8'h00;
	endproperty
	a_byte_read: assert property (p_byte_read) else $error("byte read upper not zero");
endmodule

bind crf_core crf_core_assertions u_crf_chk (.clk(clk), .resetn(resetn), .ce(ce),
	.opa_word(opa_word), .opa_data(opa_data), .alu_go(alu_go), .alu_op(alu_op),
	.alu_word(alu_word), .alu_a(alu_a), .alu_b(alu_b), .alu_result(alu_result),
	.flg_go(flg_go), .flg_op(flg_op), .flg_imm(flg_imm), .condition_flags(condition_flags),
	.irq_masked(irq_masked), .br_cond(br_cond), .br_taken(br_taken),
	.program_counter(program_counter), .fetch_addr(fetch_addr), .vec_req(vec_req),
	.vec_valid(vec_valid), .vec_data(vec_data), .cpu_ready(cpu_ready), .exc_start(exc_start));

//--- verif/test_crf_core.sv
// Self-checking bench for the register file and flags
`include "crf_map.vh"
module test_crf_core;
	timeunit 1ns;
	timeprecision 100ps;
	reg clk = 0, resetn = 0, ce = 1, opa_word = 0, opb_word = 0, wr_en = 0, wr_word = 0;
	reg alu_go = 0, alu_word = 0, alu_wb = 0, bit_go = 0, flg_go = 0, pc_step = 0, pc_load = 0;
	reg vec_valid = 0, sp_push = 0, sp_pop = 0, exc_start = 0;
	reg [3:0] opa_sel = 0, opb_sel = 0, wr_sel = 0, alu_op = 0, alu_dst = 0, br_cond = 0;
	reg [2:0] addr_sel = 0, bit_op = 0, bit_num = 0;
	reg [15:0] wr_data = 0, alu_a = 0, alu_b = 0, pc_target = 0, vec_data = 0;
	reg [7:0] bit_byte = 0, flg_imm = 0;
	reg [1:0] flg_op = 0;
	wire [15:0] opa_data, opb_data, addr_data, alu_result, program_counter, fetch_addr;
	wire [15:0] vec_addr, stack_pointer;
	wire [7:0] bit_result, condition_flags;
	wire alu_done, bit_done, irq_masked, br_taken, vec_req, cpu_ready;
	int n_errors = 0;
	int samples_checked = 0;
	crf_core DUT (.clk(clk), .resetn(resetn), .ce(ce), .opa_sel(opa_sel), .opa_word(opa_word),
		.opa_data(opa_data), .opb_sel(opb_sel), .opb_word(opb_word), .opb_data(opb_data),
		.addr_sel(addr_sel), .addr_data(addr_data), .wr_en(wr_en), .wr_sel(wr_sel),
		.wr_word(wr_word), .wr_data(wr_data), .alu_go(alu_go), .alu_op(alu_op),
		.alu_word(alu_word), .alu_a(alu_a), .alu_b(alu_b), .alu_wb(alu_wb), .alu_dst(alu_dst),
		.alu_result(alu_result), .alu_done(alu_done), .bit_go(bit_go), .bit_op(bit_op),
		.bit_num(bit_num), .bit_byte(bit_byte), .bit_result(bit_result), .bit_done(bit_done),
		.flg_go(flg_go), .flg_op(flg_op), .flg_imm(flg_imm), .condition_flags(condition_flags),
		.irq_masked(irq_masked), .br_cond(br_cond), .br_taken(br_taken), .pc_step(pc_step),
		.pc_load(pc_load), .pc_target(pc_target), .program_counter(program_counter),
		.fetch_addr(fetch_addr), .vec_req(vec_req), .vec_addr(vec_addr), .vec_valid(vec_valid),
		.vec_data(vec_data), .cpu_ready(cpu_ready), .sp_push(sp_push), .sp_pop(sp_pop),
		.stack_pointer(stack_pointer), .exc_start(exc_start));
	// ----------------------------------------
	// Access tasks
	// ----------------------------------------
	initial begin
		forever #12.5 clk = ~clk;
	end
	// Inputs move 1 ns after the edge, so registered outputs are settled by then
	task tick;
		@(posedge clk);
		#1;
	endtask
	task chk(input string nm, input [15:0] e, input [15:0] g);
		samples_checked++;
		if (g !== e) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask
	task wreg(input [3:0] s, input w, input [15:0] d);
		wr_en = 1; wr_sel = s; wr_word = w; wr_data = d;
		tick;
		wr_en = 0;
		tick;
	endtask
	task rd(input [3:0] s, input w, input [2:0] a);
		opa_sel = s; opa_word = w; addr_sel = a;
		opb_sel = s ^ 4'h8;
		opb_word = w;
		tick;
	endtask
	task flg(input [1:0] o, input [7:0] v);
		flg_go = 1; flg_op = o; flg_imm = v;
		tick;
		flg_go = 0;
		tick;
	endtask
	task bitop(input [2:0] o, input [2:0] n, input [7:0] by);
		bit_go = 1; bit_op = o; bit_num = n; bit_byte = by;
		tick;
		bit_go = 0;
		chk("bit_done", 16'h0001, {15'h0000, bit_done});
		tick;
	endtask
	task alu_case(input [3:0] o, input w, input [15:0] a, b, input [7:0] fi, input [15:0] er,
		input [7:0] ef);
		flg(`CRF_FLG_LOAD, fi);
		alu_go = 1; alu_op = o; alu_word = w; alu_a = a; alu_b = b;
		tick;
		alu_go = 0;
		chk("alu_done", 16'h0001, {15'h0000, alu_done});
		chk("alu_result", er, alu_result & (w ? 16'hFFFF : 16'h00FF));
		chk("condition_flags", {8'h00, ef}, {8'h00, condition_flags});
	endtask
	task end_sim;
		$display("comparisons %0d mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		repeat (2000) @(posedge clk);
		n_errors++;
		end_sim;
	end
	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		repeat (20) tick;
		resetn = 1;
		chk("condition_flags", 16'h0080, {8'h00, condition_flags});
		chk("ready_wait", 16'h0001, {14'h0000, cpu_ready, vec_req});
		chk("vec_addr", 16'h0000, vec_addr);
		tick;
		vec_valid = 1; vec_data = 16'h1235;
		tick;
		vec_valid = 0;
		chk("program_counter", 16'h1234, program_counter);
		chk("cpu_ready", 16'h0001, {15'h0000, cpu_ready});
		pc_load = 1; pc_target = 16'hABCD;
		tick;
		pc_load = 0; pc_step = 1;
		chk("fetch_addr", 16'hABCC, fetch_addr);
		tick;
		pc_step = 0;
		chk("fetch_addr", 16'hABCE, fetch_addr);
		wreg(4'h7, 1, 16'h0400);
		chk("stack_pointer", 16'h0400, stack_pointer);
		sp_push = 1;
		tick;
		sp_push = 0;
		chk("stack_pointer", 16'h03FE, stack_pointer);
		sp_pop = 1;
		tick;
		sp_pop = 0;
		chk("stack_pointer", 16'h0400, stack_pointer);
		wreg(4'h1, 1, 16'h1234);
		wreg(4'h9, 0, 16'h00AB);
		rd(4'h1, 1, 3'h1);
		chk("opa_data", 16'h12AB, opa_data);
		chk("addr_data", 16'h12AB, addr_data);
		rd(4'h1, 0, 3'h7);
		chk("opa_data", 16'h0012, opa_data);
		chk("addr_data", 16'h0400, addr_data);
		chk("opb_data", 16'h00AB, opb_data);
		flg(`CRF_FLG_LOAD, 8'h50);
		chk("condition_flags", 16'h0050, {8'h00, condition_flags});
		flg(`CRF_FLG_AND, 8'hF0);
		flg(`CRF_FLG_OR, 8'h0F);
		chk("condition_flags", 16'h005F, {8'h00, condition_flags});
		flg(`CRF_FLG_XOR, 8'hFF);
		chk("condition_flags", 16'h00A0, {8'h00, condition_flags});
		chk("irq_masked", 16'h0001, {15'h0000, irq_masked});
		flg(`CRF_FLG_LOAD, 8'h00);
		chk("irq_masked", 16'h0000, {15'h0000, irq_masked});
		exc_start = 1;
		tick;
		exc_start = 0;
		chk("condition_flags", 16'h0080, {8'h00, condition_flags});
		ce = 0;
		flg(`CRF_FLG_LOAD, 8'h55);
		ce = 1;
		chk("frozen_flags", 16'h0080, {8'h00, condition_flags});
		alu_wb = 1;
		alu_dst = 4'h2;
		alu_case(`CRF_OP_ADD, 0, 16'h0008, 16'h0008, 8'h00, 16'h0010, 8'h20);
		alu_case(`CRF_OP_ADD, 0, 16'h00FF, 16'h0001, 8'h00, 16'h0000, 8'h25);
		alu_case(`CRF_OP_ADD, 0, 16'h007F, 16'h0001, 8'h00, 16'h0080, 8'h2A);
		alu_case(`CRF_OP_SUB, 0, 16'h0010, 16'h0001, 8'h00, 16'h000F, 8'h20);
		alu_case(`CRF_OP_SUB, 0, 16'h0000, 16'h0001, 8'h00, 16'h00FF, 8'h29);
		alu_case(`CRF_OP_ADD, 1, 16'h0800, 16'h0800, 8'h00, 16'h1000, 8'h20);
		alu_case(`CRF_OP_ADDX, 0, 16'h0001, 16'h0001, 8'h01, 16'h0003, 8'h00);
		alu_case(`CRF_OP_SHL, 0, 16'h0081, 16'h0000, 8'h00, 16'h0002, 8'h01);
		alu_case(`CRF_OP_AND, 0, 16'h00F0, 16'h000F, 8'h00, 16'h0000, 8'h04);
		alu_case(`CRF_OP_DAA, 0, 16'h0015, 16'h0000, 8'h20, 16'h001B, 8'h20);
		alu_case(`CRF_OP_NEG, 0, 16'h0001, 16'h0000, 8'h00, 16'h00FF, 8'h29);
		alu_case(`CRF_OP_ROTR, 0, 16'h0001, 16'h0000, 8'h00, 16'h0080, 8'h09);
		alu_case(`CRF_OP_CMP, 1, 16'h1000, 16'h0001, 8'h00, 16'h0FFF, 8'h20);
		rd(4'h2, 1, 3'h2);
		chk("opa_data", 16'h8000, opa_data);
		chk("addr_data", 16'h8000, addr_data);
		flg(`CRF_FLG_LOAD, 8'h00);
		bitop(`CRF_BIT_LOAD, 3'h7, 8'h80);
		chk("condition_flags", 16'h0001, {8'h00, condition_flags});
		bitop(`CRF_BIT_STORE, 3'h3, 8'h00);
		chk("bit_result", 16'h0008, {8'h00, bit_result});
		bitop(`CRF_BIT_AND, 3'h0, 8'hFE);
		chk("condition_flags", 16'h0000, {8'h00, condition_flags});
		bitop(`CRF_BIT_TEST, 3'h1, 8'h00);
		chk("condition_flags", 16'h0004, {8'h00, condition_flags});
		flg(`CRF_FLG_LOAD, 8'h04);
		br_cond = 4'h7;
		tick;
		chk("br_taken", 16'h0001, {15'h0000, br_taken});
		br_cond = 4'h6;
		tick;
		chk("br_taken", 16'h0000, {15'h0000, br_taken});
		flg(`CRF_FLG_LOAD, 8'h01);
		br_cond = 4'h5;
		tick;
		chk("br_taken", 16'h0001, {15'h0000, br_taken});
		end_sim;
	end
endmodule
